// ==== design/mstc_defines.vh ====
// Purpose: constants for the MAC statistics counter block
// Assumes: one clock, synchronous active-high reset
// Notes: counter widths and size-bin limits live here
`ifndef MSTC_DEFINES_VH
`define MSTC_DEFINES_VH
`define MSTC_CNT_W 32
`define MSTC_LEN_W 16
`define MSTC_COLL_W 5
`define MSTC_CNT_ZERO 32'h0000_0000
`define MSTC_CNT_ONE 32'h0000_0001
`define MSTC_COLL_ONE 5'h01
`define MSTC_COLL_TWO 5'h02
`define MSTC_COLL_MAX_RETRY 5'h0F
`define MSTC_COLL_EXCESSIVE 5'h10
`define MSTC_LEN_64 16'h0040
`define MSTC_LEN_65 16'h0041
`define MSTC_LEN_127 16'h007F
`define MSTC_LEN_128 16'h0080
`define MSTC_LEN_255 16'h00FF
`define MSTC_LEN_256 16'h0100
`define MSTC_LEN_511 16'h01FF
`define MSTC_LEN_512 16'h0200
`define MSTC_LEN_1023 16'h03FF
`define MSTC_LEN_1024 16'h0400
`define MSTC_NBINS 6
`endif

// ==== design/mstc_stat_counters.v ====
// Purpose: Ethernet MAC transmit/receive statistics counters
// Assumes: engines report one final outcome pulse per frame, attempt pulses per retry
// Notes: counters wrap; all outputs are registers
//        size bins trail the direct counters by one clock
`timescale 1ns/1ns
`include "mstc_defines.vh"
module mstc_stat_counters (
    input wire mclk, // device clock, 10 MHz
    input wire rst, // synchronous reset, active high
    input wire txDone, // one-cycle pulse: final transmit outcome known
    input wire [15:0] txLen, // bytes transmitted in the final attempt
    input wire [4:0] txCollCount, // non-late collisions seen by this frame
    input wire tx_late_collision_count, // frame abandoned on a late collision
    input wire txCarrierLoss, // carrier dropped or never seen
    input wire tx_fifo_underrun_count, // transmit FIFO ran dry
    input wire txAttemptEnd, // one-cycle pulse: attempt ended by collision or loss
    input wire [15:0] txAttemptLen, // bytes sent in that attempt before it ended
    input wire rxDone, // one-cycle pulse: receive frame finished
    input wire [15:0] rxLen, // received frame bytes counted for the network total
    input wire rxAccepted, // address matched or promiscuous accept
    input wire rxStartOverrun, // no FIFO cell or buffer at frame start
    input wire rxMiddleOverrun, // resources ran out after a good start
    input wire rxZeroHeadPtr, // zero head descriptor met at start or middle
    input wire [15:0] maxReceiveFrameLength, // configured maximum receive length
    output reg [31:0] txSingleCollisionCount, // single-collision frames
    output reg [31:0] txMultipleCollisionCount, // 2..15 collision frames
    output reg [31:0] txExcessiveCollisionCount, // abandoned after 16 collisions
    output reg [31:0] txLateCollisionCount, // late-collision frames
    output reg [31:0] txFifoUnderrunCount, // underrun frames
    output reg [31:0] txCarrierLossCount, // carrier-loss frames
    output reg [31:0] txGoodByteTotal, // bytes of good transmit frames
    output reg [31:0] sizeBinExactMin, // 64 byte frames
    output reg [31:0] sizeBinSmall, // 65..127 byte frames
    output reg [31:0] sizeBinMediumSmall, // 128..255 byte frames
    output reg [31:0] sizeBinMedium, // 256..511 byte frames
    output reg [31:0] sizeBinLarge, // 512..1023 byte frames
    output reg [31:0] sizeBinLargest, // 1024..max byte frames
    output reg [31:0] networkByteTotal, // utilisation byte total
    output reg [31:0] rxStartOverrunCount, // start-of-frame overruns
    output reg [31:0] rxMiddleOverrunCount, // middle-of-frame overruns
    output reg [31:0] rxBufferOverrunCount // zero head descriptor overruns
);

    // transmit outcome classes
    wire txLate; // late collision ended this frame
    wire txClean; // no carrier loss and no underrun
    wire txExcess; // sixteen non-late collisions
    wire txGood; // good frame for byte total
    wire [31:0] txLenW; // zero-extended transmit length
    wire [31:0] rxLenW; // zero-extended receive length
    wire [31:0] attLenW; // zero-extended attempt length
    wire [31:0] netAdd; // bytes added to network total this cycle
    // size-bin qualification per direction
    wire txBinOk; // transmit frame eligible for a size bin
    wire rxBinOk; // receive frame eligible for a size bin
    wire [5:0] txBinHit; // transmit bin one-hot
    wire [5:0] rxBinHit; // receive bin one-hot
    wire [31:0] binQ [0:5]; // bin register view
    wire [5:0] txBinMask; // bins open to a carrier-cut transmit
    // per-counter increment strobes, one per final report
    wire txSingleHit; // one non-late collision, clean
    wire txMultiHit; // two to fifteen non-late collisions, clean
    wire txExcessHit; // abandoned after sixteen collisions, clean
    wire txUnderHit; // transmit fifo ran dry
    wire txLossHit; // carrier lost or never seen
    wire txGoodHit; // good frame for the byte total
    wire rxStartHit; // accepted frame refused at its start
    wire rxMiddleHit; // accepted frame lost after a good start
    wire rxBufferHit; // accepted frame met a zero head descriptor

    // once per frame
    // every frame-based counter keys off the single txDone or rxDone pulse
    assign txLate = txDone & tx_late_collision_count;
    assign txClean = ~txCarrierLoss & ~tx_fifo_underrun_count;
    assign txExcess = (txCollCount == `MSTC_COLL_EXCESSIVE) & ~tx_late_collision_count;
    assign txGood = ~tx_late_collision_count & ~txExcess & txClean;
    assign txLenW = {16'h0000, txLen};
    assign rxLenW = {16'h0000, rxLen};
    assign attLenW = {16'h0000, txAttemptLen};

    // clean tx frames
    // tx bins need no late/excessive collision or underrun; a carrier error shuts all but the 64 byte bin
    assign txBinOk = txDone & ~tx_late_collision_count & ~txExcess & ~tx_fifo_underrun_count;
    // carrier loss shuts every bin except the exact 64 byte one
    assign txBinMask = {{5{~txCarrierLoss}}, 1'b1};
    // rx bins ignore crc, alignment, code errors and overruns
    assign rxBinOk = rxDone & rxAccepted;

    // per-bin length decode for both directions
    function [5:0] binOf;
        input [15:0] len;
        input [15:0] maxLen;
        begin
            binOf = 6'h00;
            binOf[0] = (len == `MSTC_LEN_64);
            binOf[1] = (len >= `MSTC_LEN_65) && (len <= `MSTC_LEN_127);
            binOf[2] = (len >= `MSTC_LEN_128) && (len <= `MSTC_LEN_255);
            binOf[3] = (len >= `MSTC_LEN_256) && (len <= `MSTC_LEN_511);
            binOf[4] = (len >= `MSTC_LEN_512) && (len <= `MSTC_LEN_1023);
            binOf[5] = (len >= `MSTC_LEN_1024) && (len <= maxLen);
        end
    endfunction

    assign txBinHit = txBinOk ? (binOf(txLen, maxReceiveFrameLength) & txBinMask) : 6'h00;
    assign rxBinHit = rxBinOk ? binOf(rxLen, maxReceiveFrameLength) : 6'h00;

    // size bins: a tx and rx frame in one cycle both count
    genvar gi;
    generate
        for (gi = 0; gi < `MSTC_NBINS; gi = gi + 1) begin : gBin
            reg [31:0] bin_q; // bin counter
            wire [31:0] bin_d; // bin next value
            assign bin_d = bin_q + {31'h0, txBinHit[gi]} + {31'h0, rxBinHit[gi]};
            // bin register update
            always @(posedge mclk) begin
                if (rst) begin
                    bin_q <= `MSTC_CNT_ZERO;
                end else begin
                    bin_q <= bin_d;
                end
            end
            assign binQ[gi] = bin_q;
        end
    endgenerate

    // errors ignored
    // rxLen already excludes any jam sent for flow control; attempts add per retry
    assign netAdd = (txDone ? txLenW : `MSTC_CNT_ZERO)
        + (txAttemptEnd ? attLenW : `MSTC_CNT_ZERO)
        + (rxDone ? rxLenW : `MSTC_CNT_ZERO);

    // increment strobes: each keys off the one final report of its frame,
    // so a retried frame can never be counted twice in a frame counter

    assign txSingleHit = txDone & ~tx_late_collision_count & txClean & (txCollCount == `MSTC_COLL_ONE);
    assign txMultiHit = txDone & ~tx_late_collision_count & txClean
        & (txCollCount >= `MSTC_COLL_TWO) & (txCollCount <= `MSTC_COLL_MAX_RETRY);
    assign txExcessHit = txDone & txExcess & txClean;
    assign txUnderHit = txDone & tx_fifo_underrun_count;
    assign txLossHit = txDone & txCarrierLoss;
    assign txGoodHit = txDone & txGood;
    assign rxStartHit = rxDone & rxAccepted & rxStartOverrun;
    assign rxMiddleHit = rxDone & rxAccepted & rxMiddleOverrun & ~rxStartOverrun;
    assign rxBufferHit = rxDone & rxAccepted & rxZeroHeadPtr;

    // single-collision frames
    // exactly one non-late collision and no loss or underrun
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            txSingleCollisionCount <= `MSTC_CNT_ZERO;
        end else if (txSingleHit) begin
            // one more frame of this class
            txSingleCollisionCount <= txSingleCollisionCount + `MSTC_CNT_ONE;
        end
    end

    // multiple-collision frames
    // a late collision keeps a frame out of this class
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            txMultipleCollisionCount <= `MSTC_CNT_ZERO;
        end else if (txMultiHit) begin
            // one more frame of this class
            txMultipleCollisionCount <= txMultipleCollisionCount + `MSTC_CNT_ONE;
        end
    end

    // excessive-collision frames
    // the engine gave up after sixteen non-late collisions
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            txExcessiveCollisionCount <= `MSTC_CNT_ZERO;
        end else if (txExcessHit) begin
            // one more abandoned frame
            txExcessiveCollisionCount <= txExcessiveCollisionCount + `MSTC_CNT_ONE;
        end
    end

    // late collision
    // counted whatever else went wrong with the frame
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            txLateCollisionCount <= `MSTC_CNT_ZERO;
        end else if (txLate) begin
            // one more late-collision frame
            txLateCollisionCount <= txLateCollisionCount + `MSTC_CNT_ONE;
        end
    end

    // underrun frames
    // the fifo ran dry at some point while the frame went out
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            txFifoUnderrunCount <= `MSTC_CNT_ZERO;
        end else if (txUnderHit) begin
            // one more underrun frame
            txFifoUnderrunCount <= txFifoUnderrunCount + `MSTC_CNT_ONE;
        end
    end

    // carrier-loss frames
    // such a frame is never retried, so its final report is its only one
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            txCarrierLossCount <= `MSTC_CNT_ZERO;
        end else if (txLossHit) begin
            // one more carrier-loss frame
            txCarrierLossCount <= txCarrierLossCount + `MSTC_CNT_ONE;
        end
    end

    // good transmit byte total
    // only frames free of late or excessive collisions, loss and underrun
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            txGoodByteTotal <= `MSTC_CNT_ZERO;
        end else if (txGoodHit) begin
            // add the final attempt's length
            txGoodByteTotal <= txGoodByteTotal + txLenW;
        end
    end

    // network utilisation total
    // adds final frames, aborted attempts and received frames every clock;
    // netAdd is zero on idle clocks, so the total simply holds then
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            networkByteTotal <= `MSTC_CNT_ZERO;
        end else begin
            // wraps at the counter width
            networkByteTotal <= networkByteTotal + netAdd;
        end
    end

    // start-of-frame overruns
    // accepted frames that found no fifo cell or buffer at their start
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            rxStartOverrunCount <= `MSTC_CNT_ZERO;
        end else if (rxStartHit) begin
            // one more refused frame
            rxStartOverrunCount <= rxStartOverrunCount + `MSTC_CNT_ONE;
        end
    end

    // middle-of-frame overruns
    // a start overrun on the same frame takes the count instead
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            rxMiddleOverrunCount <= `MSTC_CNT_ZERO;
        end else if (rxMiddleHit) begin
            // one more frame cut short
            rxMiddleOverrunCount <= rxMiddleOverrunCount + `MSTC_CNT_ONE;
        end
    end

    // zero head descriptor overruns
    // independent of the fifo overrun classes above
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            rxBufferOverrunCount <= `MSTC_CNT_ZERO;
        end else if (rxBufferHit) begin
            // one more frame without a buffer
            rxBufferOverrunCount <= rxBufferOverrunCount + `MSTC_CNT_ONE;
        end
    end

    // size-bin outputs
    // copy the bins out so each output is one register stage;
    // this costs one clock of latency against the direct counters
    always @(posedge mclk) begin
        if (rst) begin
            // cleared by reset
            sizeBinExactMin <= `MSTC_CNT_ZERO;
            sizeBinSmall <= `MSTC_CNT_ZERO;
            sizeBinMediumSmall <= `MSTC_CNT_ZERO;
            sizeBinMedium <= `MSTC_CNT_ZERO;
            sizeBinLarge <= `MSTC_CNT_ZERO;
            sizeBinLargest <= `MSTC_CNT_ZERO;
        end else begin
            // follow the bin registers
            sizeBinExactMin <= binQ[0];
            sizeBinSmall <= binQ[1];
            sizeBinMediumSmall <= binQ[2];
            sizeBinMedium <= binQ[3];
            sizeBinLarge <= binQ[4];
            sizeBinLargest <= binQ[5];
        end
    end

endmodule // mstc_stat_counters

// ==== testbench/mstc_stat_properties.sv ====
// Purpose: port checks for the MAC statistics counters
// Assumes: one clock, synchronous active-high reset
// Notes: direct counters step one cycle after the report pulse
`timescale 1ns/1ns
module mstc_stat_checker (
    input wire mclk, input wire rst, input wire txDone, input wire [15:0] txLen,
    input wire [4:0] txCollCount, input wire tx_late_collision_count, input wire txCarrierLoss,
    input wire tx_fifo_underrun_count, input wire txAttemptEnd, input wire rxDone,
    input wire rxAccepted, input wire rxStartOverrun,
    input wire [31:0] txSingleCollisionCount, input wire [31:0] txMultipleCollisionCount,
    input wire [31:0] txExcessiveCollisionCount, input wire [31:0] txLateCollisionCount,
    input wire [31:0] txFifoUnderrunCount, input wire [31:0] txCarrierLossCount,
    input wire [31:0] txGoodByteTotal, input wire [31:0] networkByteTotal,
    input wire [31:0] rxStartOverrunCount
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // final transmit report free of late collision, carrier loss and underrun
    wire txClean = txDone && !tx_late_collision_count && !txCarrierLoss && !tx_fifo_underrun_count;
    // counter goes up by exactly one the cycle after its cause
    property stepOne(logic c, logic [31:0] v);
        c |=> v == $past(v) + 32'h1;
    endproperty
    a_multi_step: assert property (stepOne(txClean && txCollCount >= 5'h02 &&
        txCollCount <= 5'h0F, txMultipleCollisionCount)) else $error("multi count wrong");
    a_excess_step: assert property (stepOne(txClean && txCollCount == 5'h10,
        txExcessiveCollisionCount)) else $error("excessive count wrong");
    a_late_step: assert property (stepOne(txDone && tx_late_collision_count,
        txLateCollisionCount)) else $error("late count wrong");
    a_late_dominates: assert property (txDone && tx_late_collision_count |=> $stable(txSingleCollisionCount)
        && $stable(txMultipleCollisionCount) && $stable(txExcessiveCollisionCount))
        else $error("late frame counted elsewhere");
    a_underrun_step: assert property (stepOne(txDone && tx_fifo_underrun_count,
        txFifoUnderrunCount)) else $error("underrun count wrong");
    a_loss_step: assert property (stepOne(txDone && txCarrierLoss,
        txCarrierLossCount)) else $error("carrier loss count wrong");
    a_good_bytes: assert property (txClean && txCollCount != 5'h10 |=>
        txGoodByteTotal == $past(txGoodByteTotal) + {16'h0000, $past(txLen)})
        else $error("good byte total wrong");
    a_net_idle: assert property (!txDone && !rxDone && !txAttemptEnd |=>
        $stable(networkByteTotal)) else $error("network total moved without traffic");
    a_start_overrun: assert property (stepOne(rxDone && rxAccepted && rxStartOverrun,
        rxStartOverrunCount)) else $error("start overrun count wrong");
    a_frame_once: assert property (!txDone |=> $stable(txLateCollisionCount) &&
        $stable(txCarrierLossCount)) else $error("frame counter moved without report");
    cover property (txDone && tx_late_collision_count);
    cover property (txAttemptEnd);
    cover property (rxDone && rxAccepted && rxStartOverrun);
endmodule // mstc_stat_checker
bind mstc_stat_counters mstc_stat_checker chk_i (.mclk, .rst, .txDone, .txLen, .txCollCount,
    .tx_late_collision_count, .txCarrierLoss, .tx_fifo_underrun_count, .txAttemptEnd, .rxDone, .rxAccepted,
    .rxStartOverrun, .txSingleCollisionCount, .txMultipleCollisionCount,
    .txExcessiveCollisionCount, .txLateCollisionCount, .txFifoUnderrunCount,
    .txCarrierLossCount, .txGoodByteTotal, .networkByteTotal, .rxStartOverrunCount);

// ==== testbench/mstc_engine_model.sv ====
// Purpose: stand-in for the MAC transmit and receive engines
// Assumes: tasks are entered just after a rising edge
// Notes: lengths and collision counts turn to junk once their pulse is over; flags hold
`timescale 1ns/1ns
module mstc_engine_model (
    input wire mclk, // device clock
    output reg txDone, output reg txAttemptEnd, output reg rxDone, // report pulses
    output reg tx_late_collision_count, output reg txCarrierLoss, output reg tx_fifo_underrun_count, // tx flags
    output reg rxAccepted, output reg rxStartOverrun, // rx flags
    output reg rxMiddleOverrun, output reg rxZeroHeadPtr, // rx flags
    output reg [15:0] txLen, output reg [15:0] txAttemptLen, output reg [15:0] rxLen, // sizes
    output reg [4:0] txCollCount // non-late collisions
);
    initial {txDone, txAttemptEnd, rxDone, tx_late_collision_count, txCarrierLoss, tx_fifo_underrun_count, rxAccepted,
        rxStartOverrun, rxMiddleOverrun, rxZeroHeadPtr, txLen, txAttemptLen, rxLen,
        txCollCount} = 63'h0;
    task automatic tx(input [15:0] len, input [4:0] c, input [2:0] f);
        txLen <= len;
        txCollCount <= c;
        {tx_late_collision_count, txCarrierLoss, tx_fifo_underrun_count} <= f;
        txDone <= 1'b1;
        @(posedge mclk);
        txDone <= 1'b0;
        {txLen, txCollCount} <= ~{len, c};
    endtask
    task automatic attempt(input [15:0] len);
        txAttemptLen <= len;
        txAttemptEnd <= 1'b1;
        @(posedge mclk);
        txAttemptEnd <= 1'b0;
        txAttemptLen <= ~len;
    endtask
    // jam bytes already left out of the length
    task automatic rx(input [15:0] len, input [3:0] f);
        rxLen <= len;
        {rxAccepted, rxStartOverrun, rxMiddleOverrun, rxZeroHeadPtr} <= f;
        rxDone <= 1'b1;
        @(posedge mclk);
        rxDone <= 1'b0;
        rxLen <= ~len;
    endtask
endmodule // mstc_engine_model

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the statistics counters
// Assumes: engine model issues one report at a time
// Notes: expected counters kept by a small reference model
`timescale 1ns/1ns
module tb;
    typedef struct packed {logic tx; logic [3:0] f; logic [4:0] c; logic [15:0] len;} mstc_row_t;
    logic mclk, rst; // clock and reset
    logic [15:0] maxLen; // largest bin limit
    wire txDone, txAttemptEnd, rxDone, tx_late_collision_count, txCarrierLoss, tx_fifo_underrun_count, rxAccepted;
    wire rxStartOverrun, rxMiddleOverrun, rxZeroHeadPtr;
    wire [15:0] txLen, txAttemptLen, rxLen;
    wire [4:0] txCollCount;
    wire [31:0] cnt [0:16]; // design counters in port order
    logic [31:0] expv [0:16] = '{default: 32'h0}; // expected counters
    int bad_count = 0, n_compared = 0;
    // flags: tx {-,late,loss,under}, rx {accepted,start,middle,zeroHead}
    mstc_row_t rows [0:16] = '{'{1'h1, 4'h0, 5'h00, 16'h0040}, '{1'h1, 4'h0, 5'h01, 16'h007F},
        '{1'h1, 4'h0, 5'h02, 16'h0080}, '{1'h1, 4'h0, 5'h0F, 16'h01FF},
        '{1'h1, 4'h0, 5'h10, 16'h0200}, '{1'h1, 4'h4, 5'h0F, 16'h03FF},
        '{1'h1, 4'h7, 5'h01, 16'h0400}, '{1'h1, 4'h2, 5'h00, 16'h0040},
        '{1'h1, 4'h2, 5'h00, 16'h0064}, '{1'h1, 4'h1, 5'h02, 16'h012C},
        '{1'h0, 4'h8, 5'h00, 16'h0041}, '{1'h0, 4'h8, 5'h00, 16'h05EE},
        '{1'h0, 4'h8, 5'h00, 16'h05EF}, '{1'h0, 4'hF, 5'h00, 16'h003F},
        '{1'h0, 4'hA, 5'h00, 16'h0400}, '{1'h0, 4'h4, 5'h00, 16'h0100},
        '{1'h0, 4'h9, 5'h00, 16'h0200}};
    mstc_engine_model mstc_engine_model_i (.mclk, .txDone, .txAttemptEnd, .rxDone, .tx_late_collision_count,
        .txCarrierLoss, .tx_fifo_underrun_count, .rxAccepted, .rxStartOverrun, .rxMiddleOverrun,
        .rxZeroHeadPtr, .txLen, .txAttemptLen, .rxLen, .txCollCount);
    mstc_stat_counters mstc_stat_counters_i (.mclk, .rst, .txDone, .txLen, .txCollCount,
        .tx_late_collision_count, .txCarrierLoss, .tx_fifo_underrun_count, .txAttemptEnd, .txAttemptLen, .rxDone, .rxLen,
        .rxAccepted, .rxStartOverrun, .rxMiddleOverrun, .rxZeroHeadPtr,
        .maxReceiveFrameLength(maxLen), .txSingleCollisionCount(cnt[0]),
        .txMultipleCollisionCount(cnt[1]), .txExcessiveCollisionCount(cnt[2]),
        .txLateCollisionCount(cnt[3]), .txFifoUnderrunCount(cnt[4]), .txCarrierLossCount(cnt[5]),
        .txGoodByteTotal(cnt[6]), .sizeBinExactMin(cnt[7]), .sizeBinSmall(cnt[8]),
        .sizeBinMediumSmall(cnt[9]), .sizeBinMedium(cnt[10]), .sizeBinLarge(cnt[11]),
        .sizeBinLargest(cnt[12]), .networkByteTotal(cnt[13]), .rxStartOverrunCount(cnt[14]),
        .rxMiddleOverrunCount(cnt[15]), .rxBufferOverrunCount(cnt[16]));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic wrap_up;
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // compare every counter against the reference after the bins settle
    task automatic compare;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        for (int i = 0; i < 17; i++) begin
            n_compared++;
            if (cnt[i] !== expv[i]) begin
                bad_count++;
                $display("BAD t=%0t idx %0d got %h exp %h", $time, i, cnt[i], expv[i]);
            end
        end
    endtask
    // reference model: launch one report and update the expected counters
    task automatic send(input mstc_row_t r);
        int b;
        logic good;
        b = r.len < 16'h0040 ? -1 : r.len == 16'h0040 ? 7 : r.len <= 16'h007F ? 8 :
            r.len <= 16'h00FF ? 9 : r.len <= 16'h01FF ? 10 : r.len <= 16'h03FF ? 11 :
            r.len <= maxLen ? 12 : -1;
        good = r.f[2:0] == 3'h0 && r.c != 5'h10;
        @(posedge mclk);
        if (r.tx) begin
            mstc_engine_model_i.tx(r.len, r.c, r.f[2:0]);
            expv[0] += good && r.c == 5'h01;
            expv[1] += good && r.c >= 5'h02 && r.c <= 5'h0F;
            expv[2] += r.f[2:0] == 3'h0 && r.c == 5'h10;
            expv[3] += r.f[2];
            expv[4] += r.f[0];
            expv[5] += r.f[1];
            if (good) expv[6] += r.len;
            if (r.f[2] || r.f[0] || r.c == 5'h10 || (r.f[1] && r.len != 16'h0040)) b = -1;
        end else begin
            mstc_engine_model_i.rx(r.len, r.f);
            expv[14] += r.f[3] && r.f[2];
            expv[15] += r.f[3] && r.f[1] && !r.f[2];
            expv[16] += r.f[3] && r.f[0];
            if (!r.f[3]) b = -1;
        end
        expv[13] += r.len;
        if (b >= 0) expv[b] += 1;
        compare;
    endtask
    initial begin
        #2_000_000;
        bad_count++;
        wrap_up;
    end
    initial begin
        rst <= 1'h1;
        maxLen <= 16'h05EE;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        for (int i = 0; i < 17; i++) send(rows[i]);
        @(posedge mclk);
        mstc_engine_model_i.attempt(16'h0123);
        expv[13] += 32'h0000_0123;
        compare;
        @(posedge mclk);
        rst <= 1'h1;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        for (int i = 0; i < 17; i++) expv[i] = 32'h0;
        compare;
        wrap_up;
    end
endmodule // tb
